// ==== design/pscs_consts.vh ====
// Constants for the preset speed command select block
`ifndef PSCS_CONSTS_VH
`define PSCS_CONSTS_VH

// Register byte addresses
`define PSCS_ADDR_SOURCE     8'h00
`define PSCS_ADDR_PRESET0    8'h04
`define PSCS_ADDR_PRESET7    8'h20
`define PSCS_ADDR_STATUS     8'h24
`define PSCS_ADDR_ANALOG     8'h28

// Reset values
`define PSCS_SOURCE_RESET    16'h0001
`define PSCS_PRESET_RESET    16'h0000

// Source select encodings
`define PSCS_SRC_INTERNAL    1'b0
`define PSCS_SRC_ANALOG      1'b1

// Preset speed range in rpm
`define PSCS_SPEED_MAX       16'sd5000
`define PSCS_SPEED_MIN       -16'sd5000

// Status field positions
`define PSCS_STAT_CODE_LSB   0
`define PSCS_STAT_SRC_BIT    4

// AXI responses
`define PSCS_RESP_OKAY       2'b00
`define PSCS_RESP_SLVERR     2'b10

`endif

// ==== design/pscs_code_reg.v ====
// Registered 3-bit preset select code
`timescale 1ns/1ps
`default_nettype none

module pscs_code_reg #(
    parameter WIDTH = 3
) (
    // Clock and reset
    input  wire             clk,
    input  wire             rst_b,
    // Level select inputs
    input  wire [WIDTH-1:0] sel_in,
    // Registered code
    output reg  [WIDTH-1:0] code
);

    // Level sampled every clock, no edge detection
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            code <= {WIDTH{1'b0}};
        end else begin
            code <= sel_in;
        end
    end

endmodule

`default_nettype wire

// ==== design/pscs_top.v ====
// Preset speed command source selection with AXI4-Lite registers
// Overview of operation
// - Source select: 0 internal, 1 analog; default 1
// - Eight signed presets, -5000..5000 rpm, reset zero
// - No selects active uses preset zero
// - Three level-sensitive inputs form 3-bit code
// - Valid input level reads as bit one
// - Function 15 is MSB, 13 is LSB
// - Code n selects preset n, segment n+1
// - Analog mode uses channel one only
`timescale 1ns/1ps
`default_nettype none
`include "pscs_consts.vh"

module pscs_top #(
    parameter SPEED_W = 16
) (
    // Clock and reset
    input  wire                      CORE_CLK,
    input  wire                      RST_B,
    // Preset select terminals, already at valid-level polarity
    input  wire                      SPEED_SELECT_BIT0,
    input  wire                      SPEED_SELECT_BIT1,
    input  wire                      SPEED_SELECT_BIT2,
    // Analog channel one, already converted to rpm
    input  wire signed [SPEED_W-1:0] ANALOG_INPUT_ONE,
    // Speed command out
    output reg  signed [SPEED_W-1:0] SPEED_COMMAND,
    output reg  [3:0]                RUNNING_SEGMENT,
    output reg                       SOURCE_IS_ANALOG,
    // AXI4-Lite write address
    input  wire [7:0]                S_AXI_AWADDR,
    input  wire                      S_AXI_AWVALID,
    output wire                      S_AXI_AWREADY,
    // AXI4-Lite write data
    input  wire [31:0]               S_AXI_WDATA,
    input  wire [3:0]                S_AXI_WSTRB,
    input  wire                      S_AXI_WVALID,
    output wire                      S_AXI_WREADY,
    // AXI4-Lite write response
    output reg  [1:0]                S_AXI_BRESP,
    output reg                       S_AXI_BVALID,
    input  wire                      S_AXI_BREADY,
    // AXI4-Lite read address
    input  wire [7:0]                S_AXI_ARADDR,
    input  wire                      S_AXI_ARVALID,
    output wire                      S_AXI_ARREADY,
    // AXI4-Lite read data
    output reg  [31:0]               S_AXI_RDATA,
    output reg  [1:0]                S_AXI_RRESP,
    output reg                       S_AXI_RVALID,
    input  wire                      S_AXI_RREADY
);

    // Register storage
    reg  [15:0]              source_sel;
    reg  signed [15:0]       preset [0:7];
    wire [2:0]               sel_code;

    // Write channel capture
    reg                      aw_held;
    reg  [7:0]               aw_addr;
    reg                      w_held;
    reg  [31:0]              w_data;
    reg  [3:0]               w_strb;

    wire                     do_write;
    wire [2:0]               wr_idx;
    wire                     wr_preset;
    wire                     wr_source;
    reg  [15:0]              next_word;
    reg  signed [15:0]       next_clamped;
    integer                  i;

    pscs_code_reg #(
        .WIDTH (3)
    ) u_code (
        .clk    (CORE_CLK),
        .rst_b  (RST_B),
        .sel_in ({SPEED_SELECT_BIT2, SPEED_SELECT_BIT1, SPEED_SELECT_BIT0}),
        .code   (sel_code)
    );

    // Address and data are each taken once, in either order
    assign S_AXI_AWREADY = !aw_held && !S_AXI_BVALID;
    assign S_AXI_WREADY  = !w_held && !S_AXI_BVALID;

    // Write commits when both halves are held
    assign do_write  = aw_held && w_held && !S_AXI_BVALID;
    assign wr_idx    = aw_addr[4:2] - 3'h1;
    assign wr_preset = (aw_addr >= `PSCS_ADDR_PRESET0) && (aw_addr <= `PSCS_ADDR_PRESET7)
                       && (aw_addr[1:0] == 2'b00);
    assign wr_source = (aw_addr == `PSCS_ADDR_SOURCE);

    // Merge byte lanes over the old word
    always @* begin
        next_word = wr_source ? source_sel : preset[wr_idx];
        if (w_strb[0]) begin
            next_word[7:0] = w_data[7:0];
        end
        if (w_strb[1]) begin
            next_word[15:8] = w_data[15:8];
        end
        // Out-of-range presets saturate, so the command never leaves range while the internal source is selected
        if ($signed(next_word) > `PSCS_SPEED_MAX) begin
            next_clamped = `PSCS_SPEED_MAX;
        end else if ($signed(next_word) < `PSCS_SPEED_MIN) begin
            next_clamped = `PSCS_SPEED_MIN;
        end else begin
            next_clamped = next_word;
        end
    end

    // Write handshake and response
    always @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            aw_held      <= 1'b0;
            aw_addr      <= 8'h00;
            w_held       <= 1'b0;
            w_data       <= 32'h00000000;
            w_strb       <= 4'h0;
            S_AXI_BVALID <= 1'b0;
            S_AXI_BRESP  <= `PSCS_RESP_OKAY;
        end else begin
            if (S_AXI_AWVALID && S_AXI_AWREADY) begin
                aw_held <= 1'b1;
                aw_addr <= S_AXI_AWADDR;
            end
            if (S_AXI_WVALID && S_AXI_WREADY) begin
                w_held <= 1'b1;
                w_data <= S_AXI_WDATA;
                w_strb <= S_AXI_WSTRB;
            end
            if (do_write) begin
                aw_held      <= 1'b0;
                w_held       <= 1'b0;
                S_AXI_BVALID <= 1'b1;
                S_AXI_BRESP  <= (wr_source || wr_preset) ? `PSCS_RESP_OKAY
                                                         : `PSCS_RESP_SLVERR;
            end else if (S_AXI_BVALID && S_AXI_BREADY) begin
                S_AXI_BVALID <= 1'b0;
            end
        end
    end

    always @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            source_sel <= `PSCS_SOURCE_RESET;
            for (i = 0; i < 8; i = i + 1) begin
                preset[i] <= `PSCS_PRESET_RESET;
            end
        end else if (do_write) begin
            if (wr_source) begin
                // Only bit 0 is meaningful; upper bits kept zero
                source_sel <= {15'h0000, next_word[0]};
            end else if (wr_preset) begin
                preset[wr_idx] <= next_clamped;
            end
        end
    end

    // Read channel: answer one cycle after the address is taken
    assign S_AXI_ARREADY = !S_AXI_RVALID;

    always @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            S_AXI_RVALID <= 1'b0;
            S_AXI_RDATA  <= 32'h00000000;
            S_AXI_RRESP  <= `PSCS_RESP_OKAY;
        end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
            S_AXI_RVALID <= 1'b1;
            S_AXI_RRESP  <= `PSCS_RESP_OKAY;
            if (S_AXI_ARADDR == `PSCS_ADDR_SOURCE) begin
                S_AXI_RDATA <= {16'h0000, source_sel};
            end else if ((S_AXI_ARADDR >= `PSCS_ADDR_PRESET0)
                         && (S_AXI_ARADDR <= `PSCS_ADDR_PRESET7)
                         && (S_AXI_ARADDR[1:0] == 2'b00)) begin
                // Sign-extended so software sees negative speeds directly
                S_AXI_RDATA <= {{16{preset[S_AXI_ARADDR[4:2] - 3'h1][15]}},
                                preset[S_AXI_ARADDR[4:2] - 3'h1]};
            end else if (S_AXI_ARADDR == `PSCS_ADDR_STATUS) begin
                S_AXI_RDATA <= {27'h0000000, source_sel[0], 1'b0, sel_code};
            end else if (S_AXI_ARADDR == `PSCS_ADDR_ANALOG) begin
                S_AXI_RDATA <= {{16{SPEED_COMMAND[15]}}, SPEED_COMMAND};
            end else begin
                S_AXI_RDATA <= 32'h00000000;
                S_AXI_RRESP <= `PSCS_RESP_SLVERR;
            end
        end else if (S_AXI_RVALID && S_AXI_RREADY) begin
            S_AXI_RVALID <= 1'b0;
        end
    end

    // Speed command output, one cycle behind the registered code
    always @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            SPEED_COMMAND    <= {SPEED_W{1'b0}};
            RUNNING_SEGMENT  <= 4'h1;
            SOURCE_IS_ANALOG <= 1'b1;
        end else begin
            SOURCE_IS_ANALOG <= source_sel[0];
            RUNNING_SEGMENT  <= {1'b0, sel_code} + 4'h1;
            if (source_sel[0] == `PSCS_SRC_ANALOG) begin
                SPEED_COMMAND <= ANALOG_INPUT_ONE;
            end else begin
                SPEED_COMMAND <= preset[sel_code];
            end
        end
    end

endmodule

`default_nettype wire

// ==== sim/pscs_chk.sv ====
// Port assertions for the preset speed select block
`timescale 1ns/1ps
`default_nettype none
module pscs_chk (
    // Clock, reset and select terminals
    input wire logic               CORE_CLK,
    input wire logic               RST_B,
    input wire logic               SPEED_SELECT_BIT0,
    input wire logic               SPEED_SELECT_BIT1,
    input wire logic               SPEED_SELECT_BIT2,
    // Speed path
    input wire logic signed [15:0] ANALOG_INPUT_ONE,
    input wire logic signed [15:0] SPEED_COMMAND,
    input wire logic [3:0]         RUNNING_SEGMENT,
    input wire logic               SOURCE_IS_ANALOG
);
    // Terminals weighted into one code, bit 2 most significant
    wire logic [2:0] sel = {SPEED_SELECT_BIT2, SPEED_SELECT_BIT1, SPEED_SELECT_BIT0};
    default clocking @(posedge CORE_CLK); endclocking
    default disable iff (!RST_B);
    a_seg_code: assert property (RST_B ##1 1 |=>
        RUNNING_SEGMENT == {1'b0, $past(sel, 2)} + 4'h1) else $error("segment lags code");
    a_idle_first: assert property ((sel == 3'h0) [*2] |=> RUNNING_SEGMENT == 4'h1)
        else $error("idle segment wrong");
    a_msb_weight: assert property ((sel == 3'h5) [*2] |=> RUNNING_SEGMENT == 4'h6)
        else $error("weight wrong");
    a_level_hold: assert property ($stable(sel) [*3] |=> $stable(RUNNING_SEGMENT))
        else $error("segment moved");
    a_seg_bounds: assert property (RUNNING_SEGMENT inside {[4'h1:4'h8]})
        else $error("segment out of range");
    a_analog_cmd: assert property ((SOURCE_IS_ANALOG && $stable(ANALOG_INPUT_ONE)) [*3]
        |-> SPEED_COMMAND == ANALOG_INPUT_ONE) else $error("analog not followed");
    a_preset_range: assert property ((!SOURCE_IS_ANALOG) [*3] |->
        SPEED_COMMAND >= -16'sh1388 && SPEED_COMMAND <= 16'sh1388) else $error("preset range");
    a_src_default: assert property ($rose(RST_B) |-> SOURCE_IS_ANALOG)
        else $error("source default wrong");
endmodule
bind pscs_top pscs_chk i_chk (.CORE_CLK, .RST_B, .SPEED_SELECT_BIT0, .SPEED_SELECT_BIT1,
    .SPEED_SELECT_BIT2, .ANALOG_INPUT_ONE, .SPEED_COMMAND, .RUNNING_SEGMENT, .SOURCE_IS_ANALOG);
`default_nettype wire

// ==== sim/pscs_host.sv ====
// Host controller model driving the preset select terminals
`timescale 1ns/1ps
`default_nettype none
module pscs_host (
    // Request from the bench
    input  wire logic       assigned,
    input  wire logic [2:0] seg_code,
    // Terminals, high is the valid level
    output logic [2:0]      sel_bits
);
    assign sel_bits = assigned ? seg_code : 3'h0;
endmodule
`default_nettype wire

// ==== sim/preset_speed_command_select_bench.sv ====
// Self-checking bench for the preset speed select block
`timescale 1ns/1ps
`default_nettype none
module preset_speed_command_select_bench;
    // Stimulus and observed signals
    logic        clk = 0, rst_b = 0, asg = 0, aw_v = 0, w_v = 0, b_r = 0, ar_v = 0, r_r = 0;
    logic [2:0]  code = 0;
    logic [7:0]  aw_a = 0, ar_a = 0;
    logic [31:0] w_d = 0;
    logic [15:0] analog = 16'hfb2e;
    wire  [2:0]  sb;
    wire  [15:0] cmd;
    wire  [3:0]  seg;
    wire         src, awrdy, wrdy, bv, arrdy, rv;
    wire  [1:0]  bresp, rresp;
    wire  [31:0] rdata;
    int          err_total = 0, n_compared = 0;
    // Rows: select code, expected segment, preset value; codes out of order
    logic [22:0] rows [8] = '{{3'h5, 4'h6, 16'h1388}, {3'h0, 4'h1, 16'hec78},
        {3'h7, 4'h8, 16'h0064}, {3'h1, 4'h2, 16'hff9c}, {3'h2, 4'h3, 16'h0001},
        {3'h4, 4'h5, 16'h0200}, {3'h6, 4'h7, 16'h0fa0}, {3'h3, 4'h4, 16'hfc18}};
    pscs_host i_host (.assigned(asg), .seg_code(code), .sel_bits(sb));
    pscs_top i_dut (
        .CORE_CLK(clk), .RST_B(rst_b), .SPEED_SELECT_BIT0(sb[0]), .SPEED_SELECT_BIT1(sb[1]),
        .SPEED_SELECT_BIT2(sb[2]), .ANALOG_INPUT_ONE(analog), .SPEED_COMMAND(cmd),
        .RUNNING_SEGMENT(seg), .SOURCE_IS_ANALOG(src), .S_AXI_AWADDR(aw_a),
        .S_AXI_AWVALID(aw_v), .S_AXI_AWREADY(awrdy), .S_AXI_WDATA(w_d), .S_AXI_WSTRB(4'h3),
        .S_AXI_WVALID(w_v), .S_AXI_WREADY(wrdy), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bv),
        .S_AXI_BREADY(b_r), .S_AXI_ARADDR(ar_a), .S_AXI_ARVALID(ar_v), .S_AXI_ARREADY(arrdy),
        .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rv), .S_AXI_RREADY(r_r));
    initial forever #25 clk = ~clk;
    // Watchdog at 5000 cycles, far beyond the roughly 120 cycles of traffic
    initial begin
        #250000;
        err_total++;
        report_and_stop;
    end
    task report_and_stop;
        $display("checks %0d errors %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task chk(input string n, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            err_total++;
            $display("[FAIL] %s exp %h got %h", n, e, g);
        end
    endtask
    // Write: address and data offered together, each dropped once taken
    task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        logic ta, tw;
        @(posedge clk);
        aw_a <= a;
        w_d <= d;
        aw_v <= 1;
        w_v <= 1;
        b_r <= 1;
        do begin
            @(negedge clk);
            ta = aw_v & awrdy;
            tw = w_v & wrdy;
            @(posedge clk);
            if (ta) aw_v <= 0;
            if (tw) w_v <= 0;
        end while ((aw_v & !ta) | (w_v & !tw));
        do @(negedge clk); while (!bv);
        chk("bresp", {30'h0, er}, {30'h0, bresp});
        @(posedge clk);
        b_r <= 0;
    endtask
    task rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        @(posedge clk);
        ar_a <= a;
        ar_v <= 1;
        r_r <= 1;
        do @(negedge clk); while (!arrdy);
        @(posedge clk);
        ar_v <= 0;
        do @(negedge clk); while (!rv);
        chk("rdata", ed, rdata);
        chk("rresp", {30'h0, er}, {30'h0, rresp});
        @(posedge clk);
        r_r <= 0;
    endtask
    initial begin
        repeat (8) @(posedge clk);
        rst_b <= 1;
        rd(8'h00, 32'h1, 2'h0);
        rd(8'h20, 32'h0, 2'h0);
        chk("cmd", 32'hfb2e, {16'h0, cmd});
        wr(8'h00, 32'h0, 2'h0);
        for (int i = 0; i < 8; i++)
            wr({3'h0, rows[i][22:20], 2'h0} + 8'h04, {16'h0, rows[i][15:0]}, 2'h0);
        asg <= 1;
        foreach (rows[i]) begin
            @(posedge clk);
            code <= rows[i][22:20];
            repeat (3) @(negedge clk);
            chk("seg", {28'h0, rows[i][19:16]}, {28'h0, seg});
            chk("cmd", {16'h0, rows[i][15:0]}, {16'h0, cmd});
        end
        // Status shows the last code (3) and internal source; command mirror follows
        rd(8'h24, 32'h3, 2'h0);
        rd(8'h28, 32'hfffffc18, 2'h0);
        wr(8'h24, 32'h7, 2'h2);
        // Unassigned terminals fall back to preset zero
        @(posedge clk);
        asg <= 0;
        repeat (3) @(negedge clk);
        chk("seg0", 32'h1, {28'h0, seg});
        chk("cmd0", 32'hec78, {16'h0, cmd});
        chk("src0", 32'h0, {31'h0, src});
        // Out-of-range preset is clipped; unmapped place is refused
        wr(8'h20, 32'h1770, 2'h0);
        rd(8'h20, 32'h1388, 2'h0);
        rd(8'h04, 32'hffffec78, 2'h0);
        wr(8'h40, 32'h5, 2'h2);
        rd(8'h40, 32'h0, 2'h2);
        // Mid-run reset returns to the analog source
        @(posedge clk);
        rst_b <= 0;
        @(negedge clk);
        chk("src", 32'h1, {31'h0, src});
        @(posedge clk);
        rst_b <= 1;
        repeat (3) @(negedge clk);
        chk("cmd", 32'hfb2e, {16'h0, cmd});
        report_and_stop;
    end
endmodule
`default_nettype wire
